// ### logic/gate_motion_controller.v
// Purpose: motor gate controller with warning light and position status
// Assumes: all inputs except clk and resetn are field pins and pass a two-stage synchroniser
// Notes: one warning delay of 5 s precedes every motion start
`timescale 1ns/1ps
`include "gate_motion_defs.vh"

module gate_motion_controller #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter WARN_TICKS = `WARN_TICKS,
  parameter FLASH_HALF_TICKS = `FLASH_HALF_TICKS,
  parameter ENHANCED = 1
) (
  input wire clk,
  input wire resetn,
  input wire stop_button_n,
  input wire open_limit_n,
  input wire closed_limit_n,
  input wire safety_bar_n,
  input wire local_open_btn,
  input wire local_close_btn,
  input wire cord_open_in,
  input wire cord_close_in,
  input wire remote_open_cmd_in,
  input wire remote_close_cmd_in,
  output reg open_contactor_out,
  output reg close_contactor_out,
  output reg warning_light_out,
  output reg open_position_status_out,
  output reg closed_position_status_out
);

  // n.c. pins reset to their idle high level so no false trip follows reset
  wire stopSync;
  wire openLimSync;
  wire closedLimSync;
  wire barSync;
  wire localOpenSync;
  wire localCloseSync;
  wire cordOpenSync;
  wire cordCloseSync;
  wire remoteOpenSync;
  wire remoteCloseSync;

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NC)
  ) syncStop (
    .clk(clk),
    .resetn(resetn),
    .pinIn(stop_button_n),
    .pinOut(stopSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NC)
  ) syncOpenLim (
    .clk(clk),
    .resetn(resetn),
    .pinIn(open_limit_n),
    .pinOut(openLimSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NC)
  ) syncClosedLim (
    .clk(clk),
    .resetn(resetn),
    .pinIn(closed_limit_n),
    .pinOut(closedLimSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NC)
  ) syncBar (
    .clk(clk),
    .resetn(resetn),
    .pinIn(safety_bar_n),
    .pinOut(barSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncLocalOpen (
    .clk(clk),
    .resetn(resetn),
    .pinIn(local_open_btn),
    .pinOut(localOpenSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncLocalClose (
    .clk(clk),
    .resetn(resetn),
    .pinIn(local_close_btn),
    .pinOut(localCloseSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncCordOpen (
    .clk(clk),
    .resetn(resetn),
    .pinIn(cord_open_in),
    .pinOut(cordOpenSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncCordClose (
    .clk(clk),
    .resetn(resetn),
    .pinIn(cord_close_in),
    .pinOut(cordCloseSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncRemoteOpen (
    .clk(clk),
    .resetn(resetn),
    .pinIn(remote_open_cmd_in),
    .pinOut(remoteOpenSync)
  );

  pin_sync2 #(
    .RESET_VAL(`SYNC_RST_NO)
  ) syncRemoteClose (
    .clk(clk),
    .resetn(resetn),
    .pinIn(remote_close_cmd_in),
    .pinOut(remoteCloseSync)
  );

  // normally closed contacts: low means active
  wire stopAct = ~stopSync;
  wire openLim = ~openLimSync;
  wire closedLim = ~closedLimSync;
  wire safetyAct = ~barSync;
  // normally open contacts: high means asserted
  wire openReq = localOpenSync | cordOpenSync | remoteOpenSync;
  wire closeReq = localCloseSync | cordCloseSync | remoteCloseSync;

  // prescaler for slow timing
  reg [23:0] preCnt;
  reg tick;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preCnt <= 24'h000000;
      tick <= 1'b0;
    end else if (preCnt == TICK_CYCLES[23:0] - 24'h000001) begin
      preCnt <= 24'h000000;
      tick <= 1'b1;
    end else begin
      preCnt <= preCnt + 24'h000001;
      tick <= 1'b0;
    end
  end

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] warnCnt;
  reg [7:0] flashCnt;
  reg flashPhase;
  reg reopenPending;

  wire warnDone = tick && (warnCnt == WARN_TICKS[7:0] - 8'h01);
  wire safetyTrip = (state == `ST_CLOSING || state == `ST_WARN_CLOSE) && safetyAct;

  always @* begin
    next_state = state;
    case (state)
      `ST_IDLE: begin
        if (stopAct) begin
          next_state = `ST_IDLE;
        end else if ((openReq || reopenPending) && !openLim) begin
          next_state = `ST_WARN_OPEN;
        end else if (closeReq && !closedLim && !safetyAct) begin
          next_state = `ST_WARN_CLOSE;
        end
      end
      `ST_WARN_OPEN: begin
        if (stopAct || openLim) begin
          next_state = `ST_IDLE;
        end else if (warnDone) begin
          next_state = `ST_OPENING;
        end
      end
      `ST_WARN_CLOSE: begin
        if (stopAct || closedLim || safetyAct) begin
          next_state = `ST_IDLE;
        end else if (warnDone) begin
          next_state = `ST_CLOSING;
        end
      end
      `ST_OPENING: begin
        // close requests ignored while opening
        if (stopAct || openLim) begin
          next_state = `ST_IDLE;
        end
      end
      `ST_CLOSING: begin
        if (stopAct || closedLim || safetyAct) begin
          next_state = `ST_IDLE;
        end
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= `ST_IDLE;
      warnCnt <= 8'h00;
      reopenPending <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        warnCnt <= 8'h00;
      end else if (tick) begin
        warnCnt <= warnCnt + 8'h01;
      end
      // stop overrides a pending reopen
      if (stopAct) begin
        reopenPending <= 1'b0;
      end else if (safetyTrip && ENHANCED != 0) begin
        reopenPending <= 1'b1;
      end else if (state == `ST_WARN_OPEN) begin
        reopenPending <= 1'b0;
      end else if (state == `ST_IDLE && openLim) begin
        reopenPending <= 1'b0; // already open, a stale reopen would linger
      end
    end
  end

  wire moving = (next_state == `ST_OPENING) || (next_state == `ST_CLOSING);
  wire warning = (next_state == `ST_WARN_OPEN) || (next_state == `ST_WARN_CLOSE);

  reg next_openContactor;
  reg next_closeContactor;
  reg next_warningLight;

  // one state drives at most one contactor, so both can never be on
  always @* begin
    next_openContactor = 1'b0;
    next_closeContactor = 1'b0;
    next_warningLight = 1'b0;
    if (next_state == `ST_OPENING) begin
      next_openContactor = 1'b1;
    end
    if (next_state == `ST_CLOSING) begin
      next_closeContactor = 1'b1;
    end
    if (moving || warning) begin
      next_warningLight = flashPhase;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flashCnt <= 8'h00;
      flashPhase <= 1'b0;
    end else if (!(moving || warning)) begin
      flashCnt <= 8'h00;
      flashPhase <= 1'b1;
    end else if (tick) begin
      if (flashCnt == FLASH_HALF_TICKS[7:0] - 8'h01) begin
        flashCnt <= 8'h00;
        flashPhase <= ~flashPhase;
      end else begin
        flashCnt <= flashCnt + 8'h01;
      end
    end
  end

  // outputs registered from the next state so a stop acts in one edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      open_contactor_out <= 1'b0;
      close_contactor_out <= 1'b0;
      warning_light_out <= 1'b0;
    end else begin
      open_contactor_out <= next_openContactor;
      close_contactor_out <= next_closeContactor;
      warning_light_out <= next_warningLight;
    end
  end

  // status follows the limits whatever the motion state
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      open_position_status_out <= 1'b0;
      closed_position_status_out <= 1'b0;
    end else begin
      open_position_status_out <= openLim;
      closed_position_status_out <= closedLim;
    end
  end

endmodule

// two-stage synchroniser for one field pin
// stage one is read by stage two only, to contain metastability
module pin_sync2 #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  input wire clk,
  input wire resetn,
  input wire pinIn,
  output reg pinOut
);

  reg stageOne;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stageOne <= RESET_VAL;
      pinOut <= RESET_VAL;
    end else begin
      stageOne <= pinIn;
      pinOut <= stageOne;
    end
  end

endmodule

// ### logic/gate_motion_defs.vh
// Purpose: constants for the gate motion controller
// Assumes: 10 MHz system clock
// Notes: times in their own unit, cycle counts derived
`ifndef GATE_MOTION_DEFS_VH
`define GATE_MOTION_DEFS_VH
`define CLK_FREQ_HZ 10000000
`define TICK_PERIOD_MS 100
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_PERIOD_MS)
`define WARN_TIME_S 5
`define WARN_TICKS ((`WARN_TIME_S * 1000) / `TICK_PERIOD_MS)
`define FLASH_HALF_MS 500
`define FLASH_HALF_TICKS (`FLASH_HALF_MS / `TICK_PERIOD_MS)
`define SYNC_RST_NC 1'b1
`define SYNC_RST_NO 1'b0
`define ST_IDLE 3'h0
`define ST_WARN_OPEN 3'h1
`define ST_WARN_CLOSE 3'h2
`define ST_OPENING 3'h3
`define ST_CLOSING 3'h4
`endif

// ### sim/gate_motion_asserts.sv
// Purpose: port checks for the gate controller
// Assumes: 2-stage input sync
// Notes: holds of 5 cover sync and output stage
`timescale 1ns/1ps
module gate_motion_asserts (
  input clk,
  input resetn,
  input stop_button_n,
  input open_limit_n,
  input closed_limit_n,
  input safety_bar_n,
  input open_contactor_out,
  input close_contactor_out,
  input open_position_status_out,
  input closed_position_status_out
);
  wire idle = !open_contactor_out && !close_contactor_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence stopHeld; !stop_button_n [*5]; endsequence
  chk_no_clash: assert property (!(open_contactor_out && close_contactor_out))
    else $error("both on");
  chk_stop_halts: assert property (stopHeld |-> idle)
    else $error("stop ignored");
  chk_bar_halts: assert property (!safety_bar_n [*5] |-> !close_contactor_out)
    else $error("bar ignored");
  chk_open_end: assert property (!open_limit_n [*5] |-> !open_contactor_out)
    else $error("open past limit");
  chk_closed_end: assert property (!closed_limit_n [*5] |-> !close_contactor_out)
    else $error("close past limit");
  chk_open_flag: assert property (!open_limit_n [*5] |-> open_position_status_out)
    else $error("open status");
  chk_closed_flag: assert property (closed_limit_n [*5] |-> !closed_position_status_out)
    else $error("closed status");
  chk_no_reverse: assert property ($rose(open_contactor_out) |-> !$past(close_contactor_out, 2))
    else $error("reversal");
endmodule
bind gate_motion_controller gate_motion_asserts chk (.*);

// ### sim/gate_plant.sv
// Purpose: gate mechanics seen by the controller
// Assumes: one position step per clock
// Notes: starts fully closed
`timescale 1ns/1ps
module gate_plant #(parameter SPAN = 15) (
  input clk,
  input openOn,
  input closeOn,
  output openLimitN,
  output closedLimitN
);
  integer pos = 0;
  always @(posedge clk) begin
    if (openOn && pos < SPAN) pos <= pos + 1;
    else if (closeOn && pos > 0) pos <= pos - 1;
  end
  // n.c. switches open at the end stop
  assign openLimitN = (pos != SPAN);
  assign closedLimitN = (pos != 0);
endmodule

// ### sim/tb.sv
// Purpose: scenario bench for gate controller
// Assumes: short tick values for run time
// Notes: inputs change on falling edge
`timescale 1ns/1ps
module tb;
  reg clk = 0;
  reg resetn = 0;
  reg stopN = 1;
  reg barN = 1;
  reg [5:0] cmd = 6'h00;
  wire openLimN, closedLimN, kOpen, kClose, light, stOpen, stClosed;
  integer fail_count = 0;
  integer comparisons = 0;
  integer n;
  always #50 clk = ~clk;
  gate_motion_controller #(.TICK_CYCLES(2), .WARN_TICKS(4), .FLASH_HALF_TICKS(1)) DUT (
    .clk(clk), .resetn(resetn), .stop_button_n(stopN), .open_limit_n(openLimN),
    .closed_limit_n(closedLimN), .safety_bar_n(barN), .local_open_btn(cmd[0]),
    .local_close_btn(cmd[1]), .cord_open_in(cmd[2]), .cord_close_in(cmd[3]),
    .remote_open_cmd_in(cmd[4]), .remote_close_cmd_in(cmd[5]),
    .open_contactor_out(kOpen), .close_contactor_out(kClose), .warning_light_out(light),
    .open_position_status_out(stOpen), .closed_position_status_out(stClosed));
  gate_plant plant (.clk(clk), .openOn(kOpen), .closeOn(kClose),
    .openLimitN(openLimN), .closedLimitN(closedLimN));
  task end_of_test;
    begin
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input got, input exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // w: 0 open contactor, 1 close contactor, 2 open status
  task waitOn(input integer w);
    begin
      n = 0;
      while ((w == 0 ? kOpen : w == 1 ? kClose : stOpen) !== 1'b1 && n < 300) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 300) begin
        fail_count = fail_count + 1;
        end_of_test;
      end
    end
  endtask
  task pulse(input [5:0] m);
    begin
      cmd = m;
      @(negedge clk);
      cmd = 6'h00;
    end
  endtask
  task openRun;
    begin
      chk(stClosed, 1'b1);
      pulse(6'h01);
      repeat (2) @(negedge clk);
      chk(light, 1'b1);
      chk(kOpen, 1'b0);
      waitOn(0);
      chk(n > 4 && n < 12, 1'b1);
      waitOn(2);
      chk(stClosed, 1'b0);
      repeat (2) @(negedge clk);
      chk(kOpen, 1'b0);
      chk(light, 1'b0);
    end
  endtask
  task closeBar;
    begin
      pulse(6'h08);
      waitOn(1);
      pulse(6'h10);
      repeat (4) @(negedge clk);
      chk(kOpen, 1'b0);
      chk(kClose, 1'b1);
      barN = 0;
      repeat (4) @(negedge clk);
      chk(kClose, 1'b0);
      barN = 1;
      waitOn(0);
      waitOn(2);
    end
  endtask
  task remoteStop;
    begin
      pulse(6'h20);
      waitOn(1);
      stopN = 0;
      repeat (4) @(negedge clk);
      chk(kClose, 1'b0);
      stopN = 1;
      repeat (20) @(negedge clk);
      chk(kClose | kOpen, 1'b0);
      pulse(6'h04);
      waitOn(0);
      waitOn(2);
      pulse(6'h02);
      waitOn(1);
      chk(kOpen, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1;
    repeat (3) @(negedge clk);
    openRun;
    closeBar;
    remoteStop;
    end_of_test;
  end
endmodule
